//--- hw/pwrdn_regs.svh
// Register map, field positions, reset values and timing constants.
`ifndef PWRDN_REGS_SVH
`define PWRDN_REGS_SVH

// ==========================================================================
// Register byte addresses (low 16 bits of the address)
`define ADDR_MODULE_STANDBY_CONTROL 16'hff5e
`define ADDR_SYSTEM_CONTROL         16'hfff2

// ==========================================================================
// Reset values
`define RST_MODULE_STANDBY_CONTROL  8'h40
`define RST_SYSTEM_CONTROL          8'h0b

// ==========================================================================
// System control fields
`define SC_STANDBY_SELECT           7
`define SC_SETTLE_HI                6
`define SC_SETTLE_LO                4
`define SC_RAM_ENABLE               0

// ==========================================================================
// Module standby control fields
`define MS_SYSCLK_OUT_DISABLE       7
`define MS_FIXED_ONE                6
`define MS_TIMER_UNIT_HALT          5
`define MS_SERIAL0_HALT             4
`define MS_SERIAL1_HALT             3
`define MS_DMA_HALT                 2
`define MS_REFRESH_HALT             1
`define MS_ADC_HALT                 0

// ==========================================================================
// Settle waits in states
`define SETTLE_CODE_8K              3'h0
`define SETTLE_CODE_16K             3'h1
`define SETTLE_CODE_32K             3'h2
`define SETTLE_CODE_64K             3'h3
`define SETTLE_CODE_128K            3'h4
`define SETTLE_CODE_1K              3'h5
`define SETTLE_STATES_8K            18'h02000
`define SETTLE_STATES_16K           18'h04000
`define SETTLE_STATES_32K           18'h08000
`define SETTLE_STATES_64K           18'h10000
`define SETTLE_STATES_128K          18'h20000
`define SETTLE_STATES_1K            18'h00400

// ==========================================================================
// Refresh control bits cleared on halt
`define REFRESH_CLEAR_MASK          8'hc0

`endif

//--- hw/pwrdn_pkg.sv
// Types shared by the power-down controller files.
package pwrdn_pkg;
  typedef enum logic [1:0] {
    PM_RUN,
    PM_SLEEP,
    PM_SW_STANDBY,
    PM_SETTLE
  } power_mode_t;
  typedef logic [17:0] settle_count_t;
endpackage

//--- hw/settle_timer.sv
// Clock-settle countdown used when leaving software standby.
`timescale 1ns/1ns
`include "pwrdn_regs.svh"
module settle_timer (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    start_i,
  input  wire logic [2:0]              code_i,
  output logic                         done_o
);
  import pwrdn_pkg::*;

  settle_count_t count_r;
  settle_count_t count_nxt;
  logic          busy_r;
  logic          busy_nxt;
  logic          done_r;
  logic          done_nxt;
  settle_count_t load;

  // ==========================================================================
  // Load value; illegal codes fall back to the longest wait as the safe side.
  always_comb begin
    unique case (code_i)
      `SETTLE_CODE_8K:   load = `SETTLE_STATES_8K;
      `SETTLE_CODE_16K:  load = `SETTLE_STATES_16K;
      `SETTLE_CODE_32K:  load = `SETTLE_STATES_32K;
      `SETTLE_CODE_64K:  load = `SETTLE_STATES_64K;
      `SETTLE_CODE_128K: load = `SETTLE_STATES_128K;
      `SETTLE_CODE_1K:   load = `SETTLE_STATES_1K;
      default:           load = `SETTLE_STATES_128K;
    endcase
  end

  // ==========================================================================
  // Counter
  always_comb begin
    count_nxt = count_r;
    busy_nxt  = busy_r;
    done_nxt  = 1'b0;
    if (start_i) begin
      count_nxt = load - 18'h00001;
      busy_nxt  = 1'b1;
    end else if (busy_r) begin
      if (count_r == 18'h00000) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        count_nxt = count_r - 18'h00001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= 18'h00000;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
    end
  end

  assign done_o = done_r;
endmodule

//--- hw/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // ==========================================================================
  // Stages; reset value is a constant tie at the instance.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= reset_val_i;
      sync_r <= reset_val_i;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule

//--- hw/power_down_module_standby.sv
// Power-down controller with module standby, Wishbone register slave.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ns
`include "pwrdn_regs.svh"
module power_down_module_standby (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [15:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // CPU side
  input  wire logic                  sleep_req_i,
  input  wire logic                  wake_irq_i,
  input  wire logic                  any_irq_i,
  // Pins
  input  wire logic                  hw_standby_pin_n_i,
  input  wire logic                  reset_pin_n_i,
  input  wire logic                  sysclk_i,
  output logic                       sysclk_pin_o,
  output logic                       sysclk_pin_oe_o,
  output logic                       io_port_oe_o,
  // Power and module control
  output pwrdn_pkg::power_mode_t     mode_o,
  output logic                       cpu_halt_o,
  output logic                       osc_stop_o,
  output logic                       irq_start_o,
  output logic                       ram_enable_o,
  output logic                       timer_unit_halt_o,
  output logic                       timer_unit_rst_o,
  output logic                       serial0_halt_o,
  output logic                       serial0_rst_o,
  output logic                       serial1_halt_o,
  output logic                       serial1_rst_o,
  output logic                       dma_halt_o,
  output logic                       dma_rst_o,
  output logic                       refresh_halt_o,
  output logic                       refresh_counter_clr_o,
  output logic [7:0]                 refresh_timer_ctrl_clr_o,
  output logic                       adc_halt_o,
  output logic                       adc_rst_o,
  output logic                       other_rst_o
);
  import pwrdn_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] pins_s;
  logic       hw_hw_standby_pin;
  logic       pin_rst;
  logic       clk_s;

  pin_sync #(.WIDTH(3)) u_pins (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .reset_val_i (3'h3),
    .d_i         ({sysclk_i, reset_pin_n_i, hw_standby_pin_n_i}),
    .q_o         (pins_s)
  );

  assign hw_hw_standby_pin = ~pins_s[0];
  assign pin_rst = ~pins_s[1];
  assign clk_s   = pins_s[2];

  // Hardware standby and the reset pin both reinitialise everything here except the pin synchronisers, which only rst_i resets.
  logic init;
  assign init = rst_i | hw_hw_standby_pin | pin_rst;

  // ==========================================================================
  // Registers and Wishbone slave
  logic [7:0]  sysctl_r;
  logic [7:0]  sysctl_nxt;
  logic [7:0]  mstby_r;
  logic [7:0]  mstby_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic        req;
  logic        hit_sc;
  logic        hit_ms;

  assign req    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign hit_sc = wb_adr_i == `ADDR_SYSTEM_CONTROL;
  assign hit_ms = wb_adr_i == `ADDR_MODULE_STANDBY_CONTROL;

  always_comb begin
    sysctl_nxt = sysctl_r;
    mstby_nxt  = mstby_r;
    ack_nxt    = req;
    rdat_nxt   = 32'h00000000;
    if (req && wb_we_i && wb_sel_i[0]) begin
      // Standby select changes only by this write or by init; wake leaves it.
      if (hit_sc) begin
        sysctl_nxt = wb_dat_i[7:0];
      end
      if (hit_ms) begin
        mstby_nxt = wb_dat_i[7:0] | `RST_MODULE_STANDBY_CONTROL;
      end
    end
    if (req && !wb_we_i) begin
      // Unmapped addresses read zero and still acknowledge.
      if (hit_sc) begin
        rdat_nxt = {24'h000000, sysctl_r};
      end
      if (hit_ms) begin
        rdat_nxt = {24'h000000, mstby_r};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      sysctl_r <= `RST_SYSTEM_CONTROL;
      mstby_r  <= `RST_MODULE_STANDBY_CONTROL;
      ack_r    <= 1'b0;
      rdat_r   <= 32'h00000000;
    end else begin
      sysctl_r <= sysctl_nxt;
      mstby_r  <= mstby_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ==========================================================================
  // Power mode sequencer
  power_mode_t mode_r;
  power_mode_t mode_nxt;
  logic        settle_start;
  logic        settle_done;

  settle_timer u_settle (
    .clk_i   (clk_i),
    .rst_i   (init),
    .start_i (settle_start),
    .code_i  (sysctl_r[`SC_SETTLE_HI:`SC_SETTLE_LO]),
    .done_o  (settle_done)
  );

  always_comb begin
    mode_nxt     = mode_r;
    settle_start = 1'b0;
    unique case (mode_r)
      PM_RUN: begin
        if (sleep_req_i) begin
          if (sysctl_r[`SC_STANDBY_SELECT]) begin
            mode_nxt = PM_SW_STANDBY;
          end else begin
            mode_nxt = PM_SLEEP;
          end
        end
      end
      PM_SLEEP: begin
        if (any_irq_i) begin
          mode_nxt = PM_RUN;
        end
      end
      PM_SW_STANDBY: begin
        if (wake_irq_i) begin
          mode_nxt     = PM_SETTLE;
          settle_start = 1'b1;
        end
      end
      PM_SETTLE: begin
        if (settle_done) begin
          mode_nxt = PM_RUN;
        end
      end
    endcase
  end

  // ==========================================================================
  // Output registers
  logic       hw_standby_pin;
  logic       halt_cpu_nxt;
  logic       irq_nxt;
  logic [5:0] halt_nxt;
  logic [5:0] halt_r;
  logic [5:0] rst_nxt;
  logic [5:0] rst_r;
  logic       clk_pin_nxt;
  logic       clk_pin_r;
  logic       clk_oe_nxt;
  logic       clk_oe_r;
  logic       io_oe_r;
  logic       cpu_halt_r;
  logic       osc_stop_r;
  logic       irq_r;
  logic       other_rst_r;
  logic       ram_en_r;
  logic [7:0] rtc_clr_r;

  // Standby covers the settle wait too: nothing runs until it ends.
  assign hw_standby_pin         = (mode_r == PM_SW_STANDBY) | (mode_r == PM_SETTLE);
  assign halt_cpu_nxt = (mode_nxt != PM_RUN);
  assign irq_nxt      = (mode_r == PM_SETTLE) & settle_done;

  // Per-module halt and reset, bit i maps to module standby bit i.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_mod
      always_comb begin
        halt_nxt[gi] = mstby_nxt[gi] | hw_standby_pin;
        // Refresh is held, not reset, by software standby.
        rst_nxt[gi]  = mstby_nxt[gi] |
                       (hw_standby_pin & (gi != `MS_REFRESH_HALT));
      end
    end
  endgenerate

  always_comb begin
    clk_pin_nxt = clk_s;
    clk_oe_nxt  = ~mstby_nxt[`MS_SYSCLK_OUT_DISABLE];
    if (hw_standby_pin) begin
      clk_pin_nxt = 1'b1;
      clk_oe_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      mode_r      <= PM_RUN;
      halt_r      <= 6'h3f;
      rst_r       <= 6'h3f;
      clk_pin_r   <= 1'b0;
      clk_oe_r    <= 1'b0;
      io_oe_r     <= 1'b0;
      cpu_halt_r  <= 1'b1;
      osc_stop_r  <= 1'b0;
      irq_r       <= 1'b0;
      other_rst_r <= 1'b1;
      ram_en_r    <= 1'b0;
      rtc_clr_r   <= `REFRESH_CLEAR_MASK;
    end else begin
      mode_r      <= mode_nxt;
      halt_r      <= halt_nxt;
      rst_r       <= rst_nxt;
      clk_pin_r   <= clk_pin_nxt;
      clk_oe_r    <= clk_oe_nxt;
      io_oe_r     <= 1'b1;
      cpu_halt_r  <= halt_cpu_nxt;
      osc_stop_r  <= (mode_nxt == PM_SW_STANDBY);
      irq_r       <= irq_nxt;
      other_rst_r <= (mode_nxt == PM_SW_STANDBY) |
                     (mode_nxt == PM_SETTLE);
      ram_en_r    <= sysctl_nxt[`SC_RAM_ENABLE];
      rtc_clr_r   <= halt_nxt[`MS_REFRESH_HALT] ?
                     `REFRESH_CLEAR_MASK : 8'h00;
    end
  end

  assign mode_o                   = mode_r;
  assign cpu_halt_o               = cpu_halt_r;
  assign osc_stop_o               = osc_stop_r;
  assign irq_start_o              = irq_r;
  assign ram_enable_o             = ram_en_r;
  assign sysclk_pin_o             = clk_pin_r;
  assign sysclk_pin_oe_o          = clk_oe_r;
  assign io_port_oe_o             = io_oe_r;
  assign timer_unit_halt_o        = halt_r[`MS_TIMER_UNIT_HALT];
  assign timer_unit_rst_o         = rst_r[`MS_TIMER_UNIT_HALT];
  assign serial0_halt_o           = halt_r[`MS_SERIAL0_HALT];
  assign serial0_rst_o            = rst_r[`MS_SERIAL0_HALT];
  assign serial1_halt_o           = halt_r[`MS_SERIAL1_HALT];
  assign serial1_rst_o            = rst_r[`MS_SERIAL1_HALT];
  assign dma_halt_o               = halt_r[`MS_DMA_HALT];
  assign dma_rst_o                = rst_r[`MS_DMA_HALT];
  assign refresh_halt_o           = halt_r[`MS_REFRESH_HALT];
  // Refresh keeps its state; only counter and top control bits clear.
  assign refresh_counter_clr_o    = halt_r[`MS_REFRESH_HALT];
  assign refresh_timer_ctrl_clr_o = rtc_clr_r;
  assign adc_halt_o               = halt_r[`MS_ADC_HALT];
  assign adc_rst_o                = rst_r[`MS_ADC_HALT];
  assign other_rst_o              = other_rst_r;
endmodule

//--- dv/power_down_module_standby_sva.sv
// Port-level assertions for the power-down controller.
`timescale 1ns/1ns
`include "pwrdn_regs.svh"
module pwrdn_checker (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_we_i,
  input wire logic [15:0]           wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  sleep_req_i,
  input wire pwrdn_pkg::power_mode_t mode_o,
  input wire logic                  cpu_halt_o,
  input wire logic                  osc_stop_o,
  input wire logic                  irq_start_o,
  input wire logic                  sysclk_pin_o,
  input wire logic                  timer_unit_halt_o,
  input wire logic                  dma_halt_o,
  input wire logic                  dma_rst_o,
  input wire logic                  refresh_halt_o,
  input wire logic                  refresh_counter_clr_o,
  input wire logic [7:0]            refresh_timer_ctrl_clr_o,
  input wire logic                  other_rst_o
);
  import pwrdn_pkg::*;
  logic [17:0] settle_cnt_r;
  logic [17:0] settle_cnt_nxt;
  logic        ms_wr;

  // ==========================================================================
  // Helper logic
  // The settle count is rebuilt here so the wake delay is checked against the six legal lengths, not the selected code.
  assign ms_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
                 && (wb_adr_i == `ADDR_MODULE_STANDBY_CONTROL);
  always_comb begin
    settle_cnt_nxt = 18'h00000;
    if (!rst_i && mode_o == PM_SETTLE) begin
      settle_cnt_nxt = settle_cnt_r + 18'h00001;
    end
  end
  always_ff @(posedge clk_i) begin
    settle_cnt_r <= settle_cnt_nxt;
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_fixed_one_read: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `ADDR_MODULE_STANDBY_CONTROL
    |-> wb_dat_o[7:0] == (wb_dat_o[7:0] | 8'h40))
    else $error("module standby read lost bit six");
  a_timer_halt_follow: assert property (
    ms_wr && mode_o == PM_RUN |=> timer_unit_halt_o == $past(wb_dat_i[5]))
    else $error("timer halt does not follow its bit");
  a_dma_halt_follow: assert property (
    ms_wr && mode_o == PM_RUN |=> dma_halt_o == $past(wb_dat_i[2]))
    else $error("dma halt does not follow its bit");
  a_sleep_halts_cpu: assert property (
    sleep_req_i && mode_o == PM_RUN |=> cpu_halt_o)
    else $error("cpu not halted after sleep request");
  a_standby_clk_high: assert property (
    mode_o == PM_SW_STANDBY && $past(mode_o) == PM_SW_STANDBY
    |-> sysclk_pin_o)
    else $error("clock pin not high in standby");
  a_standby_resets: assert property (
    mode_o == PM_SW_STANDBY && $past(mode_o) == PM_SW_STANDBY
    |-> other_rst_o && dma_rst_o && osc_stop_o && cpu_halt_o)
    else $error("standby does not stop and reset");
  a_refresh_clear: assert property (
    refresh_halt_o |-> refresh_counter_clr_o
    && refresh_timer_ctrl_clr_o == `REFRESH_CLEAR_MASK)
    else $error("refresh halt clears wrong bits");
  a_settle_length: assert property (
    irq_start_o |-> settle_cnt_r inside {18'h00401, 18'h02001, 18'h04001,
                                         18'h08001, 18'h10001, 18'h20001})
    else $error("settle wait length not a legal value");
  a_settle_bound: assert property (
    mode_o == PM_SETTLE |-> settle_cnt_r <= 18'h20000)
    else $error("settle wait overran the longest code");
endmodule

bind power_down_module_standby pwrdn_checker u_pwrdn_checker (
  .clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .sleep_req_i, .mode_o, .cpu_halt_o, .osc_stop_o, .irq_start_o,
  .sysclk_pin_o, .timer_unit_halt_o, .dma_halt_o, .dma_rst_o,
  .refresh_halt_o, .refresh_counter_clr_o, .refresh_timer_ctrl_clr_o,
  .other_rst_o);

//--- dv/tb_top.sv
// Self-checking bench for the power-down controller.
`timescale 1ns/1ns
`include "pwrdn_regs.svh"
module tb_top;
  import pwrdn_pkg::*;
  localparam logic [15:0] ms_adr = `ADDR_MODULE_STANDBY_CONTROL;
  localparam logic [15:0] sc_adr = `ADDR_SYSTEM_CONTROL;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, sleep_req_i = 1'b0, wake_irq_i = 1'b0;
  logic        any_irq_i = 1'b0, hw_standby_pin_n_i = 1'b1;
  logic        reset_pin_n_i = 1'b1, sysclk_i = 1'b0;
  logic        sysclk_pin_o, sysclk_pin_oe_o, io_port_oe_o, cpu_halt_o;
  logic        osc_stop_o, irq_start_o, ram_enable_o, other_rst_o;
  logic        timer_unit_halt_o, timer_unit_rst_o, serial0_halt_o;
  logic        serial0_rst_o, serial1_halt_o, serial1_rst_o, dma_halt_o;
  logic        dma_rst_o, refresh_halt_o, refresh_counter_clr_o;
  logic        adc_halt_o, adc_rst_o;
  logic [7:0]  refresh_timer_ctrl_clr_o;
  logic [5:0]  halts, rsts;
  power_mode_t mode_o;
  int          n_fail = 0, total_checks = 0;

  assign halts = {timer_unit_halt_o, serial0_halt_o, serial1_halt_o,
                  dma_halt_o, refresh_halt_o, adc_halt_o};
  assign rsts = {timer_unit_rst_o, serial0_rst_o, serial1_rst_o, dma_rst_o,
                 refresh_counter_clr_o, adc_rst_o};

  power_down_module_standby u_power_down_module_standby (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_req_i, .wake_irq_i, .any_irq_i,
    .hw_standby_pin_n_i, .reset_pin_n_i, .sysclk_i, .sysclk_pin_o,
    .sysclk_pin_oe_o, .io_port_oe_o, .mode_o, .cpu_halt_o, .osc_stop_o,
    .irq_start_o, .ram_enable_o, .timer_unit_halt_o, .timer_unit_rst_o,
    .serial0_halt_o, .serial0_rst_o, .serial1_halt_o, .serial1_rst_o,
    .dma_halt_o, .dma_rst_o, .refresh_halt_o, .refresh_counter_clr_o,
    .refresh_timer_ctrl_clr_o, .adc_halt_o, .adc_rst_o, .other_rst_o);

  // ==========================================================================
  // Clock and shared tasks
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) sysclk_i <= ~sysclk_i;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Values seen right after an edge are the ones the design sampled there.
  task automatic wb(input logic we, input logic [15:0] adr,
                    input logic [7:0] dat, input logic [3:0] sel);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, dat};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) chk("bus answer", 32'h0, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [15:0] adr,
                       input logic [31:0] exp);
    wb(1'b0, adr, 8'h00, 4'h1);
    chk(nm, rd, exp);
  endtask

  task automatic sleep_pulse();
    @(posedge clk_i) sleep_req_i <= 1'b1;
    @(posedge clk_i) sleep_req_i <= 1'b0;
    step(1);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rdchk("module standby reset", ms_adr, `RST_MODULE_STANDBY_CONTROL);
    rdchk("system control reset", sc_adr, `RST_SYSTEM_CONTROL);
    chk("halts after reset", halts, 32'h0);
    chk("clock pin enable", sysclk_pin_oe_o, 32'h1);
    chk("ram enable", ram_enable_o, 32'h1);
    for (int c = 0; c < 6; c++) begin
      wb(1'b1, sc_adr, {1'b0, c[2:0], 4'hb}, 4'h1);
      rdchk("settle code", sc_adr, {25'h0, c[2:0], 4'hb});
    end
    $display("test reset done");
  endtask

  task automatic t_module_halt();
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, ms_adr, 8'h01 << i, 4'h1);
      step(1);
      chk("one halt", halts, 32'h1 << i);
      chk("one module reset", rsts, 32'h1 << i);
      rdchk("halt readback", ms_adr, 32'h40 | (32'h1 << i));
    end
    wb(1'b1, ms_adr, 8'h21, 4'h0);
    rdchk("unselected write", ms_adr, 32'h60);
    rdchk("unmapped read", 16'hff5f, 32'h0);
    wb(1'b1, ms_adr, 8'h80, 4'h1);
    step(2);
    chk("clock pin off", sysclk_pin_oe_o, 32'h0);
    rdchk("bit six kept", ms_adr, 32'hc0);
    wb(1'b1, ms_adr, 8'h00, 4'h1);
    step(2);
    chk("clock pin on", sysclk_pin_oe_o, 32'h1);
    chk("all released", halts, 32'h0);
    $display("test module halt done");
  endtask

  task automatic t_sleep();
    wb(1'b1, ms_adr, 8'h04, 4'h1);
    wb(1'b1, sc_adr, 8'h0b, 4'h1);
    sleep_pulse();
    chk("sleep mode", mode_o, PM_SLEEP);
    chk("cpu halted", cpu_halt_o, 32'h1);
    chk("halted module stays", halts, 32'h04);
    chk("oscillator runs", osc_stop_o, 32'h0);
    @(posedge clk_i) any_irq_i <= 1'b1;
    @(posedge clk_i) any_irq_i <= 1'b0;
    step(1);
    chk("sleep left", mode_o, PM_RUN);
    $display("test sleep done");
  endtask

  task automatic t_standby();
    int n;
    n = 0;
    wb(1'b1, ms_adr, 8'h01, 4'h1);
    wb(1'b1, sc_adr, 8'hdb, 4'h1);
    sleep_pulse();
    @(posedge clk_i) any_irq_i <= 1'b1;
    step(4);
    chk("standby mode", mode_o, PM_SW_STANDBY);
    chk("oscillator stopped", osc_stop_o, 32'h1);
    chk("peripherals reset", {other_rst_o, dma_rst_o}, 32'h3);
    chk("refresh ctrl clear", refresh_timer_ctrl_clr_o, 32'hc0);
    chk("clock pin high", sysclk_pin_o, 32'h1);
    any_irq_i <= 1'b0;
    wake_irq_i <= 1'b1;
    while (irq_start_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      wake_irq_i <= 1'b0;
      if (mode_o === PM_SETTLE) n++;
      if (mode_o === PM_SETTLE && cpu_halt_o !== 1'b1) n = 5000;
    end
    chk("settle states", n, `SETTLE_STATES_1K + 1);
    step(1);
    chk("cpu resumed", {mode_o, cpu_halt_o}, 32'h0);
    rdchk("select kept", sc_adr, 32'hdb);
    rdchk("standby kept halts", ms_adr, 32'h41);
    wb(1'b1, sc_adr, 8'h5b, 4'h1);
    rdchk("select cleared", sc_adr, 32'h5b);
    $display("test standby done");
  endtask

  task automatic t_pins();
    wb(1'b1, ms_adr, 8'h9f, 4'h1);
    wb(1'b1, sc_adr, 8'h0a, 4'h1);
    chk("ram off before standby", ram_enable_o, 32'h0);
    @(posedge clk_i) hw_standby_pin_n_i <= 1'b0;
    step(5);
    chk("ports floated", {io_port_oe_o, sysclk_pin_oe_o}, 32'h0);
    chk("all held", {halts, other_rst_o}, 32'h7f);
    @(posedge clk_i) hw_standby_pin_n_i <= 1'b1;
    step(5);
    rdchk("hw standby init", ms_adr, 32'h40);
    rdchk("hw standby sysctl", sc_adr, 32'h0b);
    wb(1'b1, ms_adr, 8'h3f, 4'h1);
    @(posedge clk_i) reset_pin_n_i <= 1'b0;
    step(5);
    @(posedge clk_i) reset_pin_n_i <= 1'b1;
    step(5);
    rdchk("pin reset init", ms_adr, 32'h40);
    $display("test pins done");
  endtask

  // ==========================================================================
  // Sequence, watchdog and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    step(12);
    rst_i <= 1'b0;
    t_reset();
    t_module_halt();
    t_sleep();
    t_standby();
    t_pins();
    results();
  end

  // The whole sequence needs about 1200 cycles.
  initial begin
    step(20000);
    n_fail++;
    results();
  end
endmodule
